//--- mbri_defs.vh
`ifndef MBRI_DEFS_VH
`define MBRI_DEFS_VH
// clock rate in hertz
`define MBRI_CLK_HZ 100000000
// tone frequency and durations in their own units
`define MBRI_TONE_HZ 4000
`define MBRI_BURST_MS 15
`define MBRI_CAD_ON_MS 122
`define MBRI_CAD_GAP_MS 610
// derived cycle counts (half period rounds down, durations round down)
`define MBRI_TONE_HALF (`MBRI_CLK_HZ / (2 * `MBRI_TONE_HZ))
`define MBRI_MS_CYC (`MBRI_CLK_HZ / 1000)
`define MBRI_BURST_CYC (`MBRI_BURST_MS * `MBRI_MS_CYC)
`define MBRI_CAD_ON_CYC (`MBRI_CAD_ON_MS * `MBRI_MS_CYC)
`define MBRI_CAD_GAP_CYC (`MBRI_CAD_GAP_MS * `MBRI_MS_CYC)
// count thresholds
`define MBRI_CONT_LIMIT 12'h013
`define MBRI_OVER_LIMIT 12'h7D0
// function codes
`define MBRI_FN_VOLT 2'h0
`define MBRI_FN_CURR 2'h1
`define MBRI_FN_OHMS 2'h2
// range codes: 0 = most sensitive (200.0 mV / 200.0 ohm) up to 4 = 2000
`define MBRI_RG_200M 3'h0
`define MBRI_RG_2 3'h1
`define MBRI_RG_20 3'h2
`define MBRI_RG_200 3'h3
`define MBRI_RG_2000 3'h4
// cadence phases
`define MBRI_PH_ON1 4'h1
`define MBRI_PH_OFF1 4'h2
`define MBRI_PH_ON2 4'h4
`define MBRI_PH_GAP 4'h8
`endif

//--- mbri_tone_gen.v
`timescale 1ns/100ps
`include "mbri_defs.vh"
// free running 4 kHz square wave from a cycle divider
module mbri_tone_gen (
   input wire clk_i,
   input wire rst_i,
   output reg tone_o
);
   reg [13:0] div_q;
   // toggle every half period
   always @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= 14'h0000;
         tone_o <= 1'b1;
      end else if (div_q == `MBRI_TONE_HALF - 1) begin
         div_q <= 14'h0000;
         tone_o <= ~tone_o;
      end else begin
         div_q <= div_q + 14'h0001;
      end
   end
endmodule

//--- mbri_core.v
`timescale 1ns/100ps
`include "mbri_defs.vh"
// Behaviour
// - ohms below 19 counts gives continuous tone
// - volt/current overrange gives interrupted tone outside extended resolution
// - overrange blinks leading digit, zeros lower three outside extended resolution
// - overrange tone above 2000 counts, any ranging
// - tone sounds during extended-resolution display
// - tone output high when idle
// - 15 ms burst on range change outside current mode
// - 15 ms burst on function or option change
// - no range burst during current measurement
// - decimal points follow voltage/resistance range
// - current ranges light second or first point
// - auto ranging keeps converter under 200 mV
// - manual ranging enables 300 mV extended resolution
// - integration resistor chosen by function
// - AC option routes rectified path switch
// - cadence 122 on, 122 off, 122 on, 610 off
// - ohms overrange makes no tone
module mbri_core (
   input wire CLOCK_I,
   input wire RST_I,
   input wire [1:0] FUNCTION_I,
   input wire AC_OPTION_I,
   input wire LOW_POWER_OHMS_OPTION_I,
   input wire CURRENT_20MA_I,
   input wire MANUAL_RANGE_I,
   input wire [2:0] RANGE_I,
   input wire [11:0] COUNT_I,
   input wire COUNT_VALID_I,
   output reg TONE_O,
   output reg LEADING_DIGIT_BLINK_O,
   output reg LOWER_DIGITS_ZERO_O,
   output reg EXTENDED_RES_O,
   output reg POINT_DRIVE_FIRST_O,
   output reg POINT_DRIVE_SECOND_O,
   output reg POINT_DRIVE_THIRD_O,
   output reg ATTENUATOR_TAP_A_O,
   output reg ATTENUATOR_TAP_B_O,
   output reg ATTENUATOR_TAP_C_O,
   output reg ATTENUATOR_TAP_D_O,
   output reg VOLT_CURRENT_INTEG_RESISTOR_O,
   output reg OHMS_INTEG_RESISTOR_O,
   output reg RECTIFIED_INPUT_SWITCH_O,
   output reg DIRECT_INPUT_SWITCH_O
);
   // cycle counts cut on purpose to the width of the counters holding them
   localparam [31:0] BURST_FULL = `MBRI_BURST_CYC;
   localparam [31:0] CAD_ON_FULL = `MBRI_CAD_ON_CYC - 1;
   localparam [31:0] CAD_GAP_FULL = `MBRI_CAD_GAP_CYC - 1;
   localparam [20:0] BURST_CYC = BURST_FULL[20:0];
   localparam [26:0] CAD_ON_LAST = CAD_ON_FULL[26:0];
   localparam [26:0] CAD_GAP_LAST = CAD_GAP_FULL[26:0];

   // decimal point pattern {third, second, first}
   function [2:0] point_map;
      input [1:0] fn;
      input [2:0] rg;
      input ma20;
      begin
         if (fn == `MBRI_FN_CURR) begin
            point_map = ma20 ? 3'h2 : 3'h1;
         end else begin
            case (rg)
               `MBRI_RG_200M: point_map = 3'h1;
               `MBRI_RG_2: point_map = 3'h4;
               `MBRI_RG_20: point_map = 3'h2;
               `MBRI_RG_200: point_map = 3'h1;
               default: point_map = 3'h0;
            endcase
         end
      end
   endfunction

   // count beyond the 2000 full-scale limit
   function count_over;
      input [11:0] cnt;
      begin
         count_over = (cnt > `MBRI_OVER_LIMIT);
      end
   endfunction

   // count low enough to call the probes shorted
   function count_short;
      input [11:0] cnt;
      begin
         count_short = (cnt < `MBRI_CONT_LIMIT);
      end
   endfunction

   // rectifier path only for AC volts or amps; ohms always reads direct
   function ac_route;
      input ac;
      input [1:0] fn;
      begin
         ac_route = ac & (fn != `MBRI_FN_OHMS);
      end
   endfunction

   // extended counts exist when the 300 mV span is open or on the 2000 range
   function ext_span;
      input manual;
      input [2:0] rg;
      begin
         ext_span = manual | (rg == `MBRI_RG_2000);
      end
   endfunction

   wire tone_sq;
   reg [1:0] fn_q;
   reg ac_q;
   reg lo_q;
   reg ma_q;
   reg [2:0] rg_q;
   reg primed_q;
   reg cont_q;
   reg over_q;
   reg ohm_over_q;
   reg ext_q;
   reg [20:0] burst_q;
   reg [3:0] phase_q;
   reg [3:0] phase_d;
   reg [26:0] cad_q;
   reg cad_done;
   wire fn_chg;
   wire rg_chg;
   wire is_ohms;
   reg tone_en;
   wire [3:0] tap_d;
   genvar gi;

   // single divider feeds every tone source
   mbri_tone_gen u_tone (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .tone_o(tone_sq)
   );

   assign is_ohms = (FUNCTION_I == `MBRI_FN_OHMS);
   assign fn_chg = primed_q & ((FUNCTION_I != fn_q) | (AC_OPTION_I != ac_q)
                   | (LOW_POWER_OHMS_OPTION_I != lo_q));
   // range change in current mode is silent
   assign rg_chg = primed_q & (FUNCTION_I != `MBRI_FN_CURR)
                   & ((RANGE_I != rg_q) | (CURRENT_20MA_I != ma_q));

   // one tap per decade above 200 mV keeps converter in span
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_tap
         localparam [31:0] TAP_FULL = gi + 1;
         localparam [2:0] TAP_RG = TAP_FULL[2:0];
         assign tap_d[gi] = ~is_ohms & (RANGE_I == TAP_RG);
      end
   endgenerate

   // remember previous settings; first cycle after reset only primes
   always @(posedge CLOCK_I) begin
      if (RST_I) begin
         fn_q <= `MBRI_FN_VOLT;
         ac_q <= 1'b0;
         lo_q <= 1'b0;
         ma_q <= 1'b0;
         rg_q <= `MBRI_RG_200M;
         primed_q <= 1'b0;
      end else begin
         fn_q <= FUNCTION_I;
         ac_q <= AC_OPTION_I;
         lo_q <= LOW_POWER_OHMS_OPTION_I;
         ma_q <= CURRENT_20MA_I;
         rg_q <= RANGE_I;
         primed_q <= 1'b1;
      end
   end

   // latch conversion verdicts; a function change clears stale ones
   // a fresh count in the same cycle wins, it was read under the new setting
   always @(posedge CLOCK_I) begin
      if (RST_I) begin
         cont_q <= 1'b0;
         over_q <= 1'b0;
         ohm_over_q <= 1'b0;
         ext_q <= 1'b0;
      end else if (COUNT_VALID_I) begin
         cont_q <= is_ohms & count_short(COUNT_I);
         over_q <= ~is_ohms & count_over(COUNT_I);
         ohm_over_q <= is_ohms & count_over(COUNT_I);
         ext_q <= ext_span(MANUAL_RANGE_I, RANGE_I) & ~is_ohms
                  & count_over(COUNT_I);
      end else if (fn_chg) begin
         cont_q <= 1'b0;
         over_q <= 1'b0;
         ohm_over_q <= 1'b0;
         ext_q <= 1'b0;
      end
   end

   // 15 ms burst, retriggered by any qualifying change
   always @(posedge CLOCK_I) begin
      if (RST_I) begin
         burst_q <= 21'h000000;
      end else if (fn_chg || rg_chg) begin
         burst_q <= BURST_CYC;
      end else if (burst_q != 21'h000000) begin
         burst_q <= burst_q - 21'h000001;
      end
   end

   // cadence phase advance
   always @* begin
      cad_done = 1'b0;
      phase_d = phase_q;
      case (phase_q)
         `MBRI_PH_ON1: begin
            cad_done = (cad_q == CAD_ON_LAST);
            if (cad_done) phase_d = `MBRI_PH_OFF1;
         end
         `MBRI_PH_OFF1: begin
            cad_done = (cad_q == CAD_ON_LAST);
            if (cad_done) phase_d = `MBRI_PH_ON2;
         end
         `MBRI_PH_ON2: begin
            cad_done = (cad_q == CAD_ON_LAST);
            if (cad_done) phase_d = `MBRI_PH_GAP;
         end
         `MBRI_PH_GAP: begin
            cad_done = (cad_q == CAD_GAP_LAST);
            if (cad_done) phase_d = `MBRI_PH_ON1;
         end
         default: begin
            cad_done = 1'b1;
            phase_d = `MBRI_PH_ON1;
         end
      endcase
   end

   // cadence runs only while overranged, restarting on the first on slot
   always @(posedge CLOCK_I) begin
      if (RST_I || !over_q) begin
         phase_q <= `MBRI_PH_ON1;
         cad_q <= 27'h0000000;
      end else begin
         phase_q <= phase_d;
         cad_q <= cad_done ? 27'h0000000 : cad_q + 27'h0000001;
      end
   end

   // tone sources; continuity and extended are steady, overrange gated
   always @* begin
      tone_en = cont_q | ext_q | (burst_q != 21'h000000)
                | (over_q & (phase_q[0] | phase_q[2]));
   end

   // registered outputs
   always @(posedge CLOCK_I) begin
      if (RST_I) begin
         TONE_O <= 1'b1;
         LEADING_DIGIT_BLINK_O <= 1'b0;
         LOWER_DIGITS_ZERO_O <= 1'b0;
         EXTENDED_RES_O <= 1'b0;
         POINT_DRIVE_FIRST_O <= 1'b0;
         POINT_DRIVE_SECOND_O <= 1'b0;
         POINT_DRIVE_THIRD_O <= 1'b0;
         ATTENUATOR_TAP_A_O <= 1'b0;
         ATTENUATOR_TAP_B_O <= 1'b0;
         ATTENUATOR_TAP_C_O <= 1'b0;
         ATTENUATOR_TAP_D_O <= 1'b0;
         VOLT_CURRENT_INTEG_RESISTOR_O <= 1'b1;
         OHMS_INTEG_RESISTOR_O <= 1'b0;
         RECTIFIED_INPUT_SWITCH_O <= 1'b0;
         DIRECT_INPUT_SWITCH_O <= 1'b1;
      end else begin
         TONE_O <= tone_en ? tone_sq : 1'b1;
         // ohms overrange still shows on the display, only the tone is muted
         LEADING_DIGIT_BLINK_O <= over_q | ext_q | ohm_over_q;
         LOWER_DIGITS_ZERO_O <= (over_q | ohm_over_q) & ~ext_q;
         EXTENDED_RES_O <= MANUAL_RANGE_I;
         {POINT_DRIVE_THIRD_O, POINT_DRIVE_SECOND_O, POINT_DRIVE_FIRST_O}
            <= point_map(FUNCTION_I, RANGE_I, CURRENT_20MA_I);
         // taps registered from the decoded vector
         ATTENUATOR_TAP_A_O <= tap_d[0];
         ATTENUATOR_TAP_B_O <= tap_d[1];
         ATTENUATOR_TAP_C_O <= tap_d[2];
         ATTENUATOR_TAP_D_O <= tap_d[3];
         VOLT_CURRENT_INTEG_RESISTOR_O <= ~is_ohms;
         OHMS_INTEG_RESISTOR_O <= is_ohms;
         // both switches from one decode so they can never overlap
         RECTIFIED_INPUT_SWITCH_O <= ac_route(AC_OPTION_I, FUNCTION_I);
         DIRECT_INPUT_SWITCH_O <= ~ac_route(AC_OPTION_I, FUNCTION_I);
      end
   end
endmodule

//--- mbri_core_monitor.sv
`timescale 1ns/100ps
`include "mbri_defs.vh"
// pin checks; outputs follow sampled settings one edge later
module mbri_core_monitor (
   input wire CLOCK_I,
   input wire RST_I,
   input wire [1:0] FUNCTION_I,
   input wire AC_OPTION_I,
   input wire CURRENT_20MA_I,
   input wire MANUAL_RANGE_I,
   input wire [2:0] RANGE_I,
   input wire [11:0] COUNT_I,
   input wire COUNT_VALID_I,
   input wire TONE_O,
   input wire LEADING_DIGIT_BLINK_O,
   input wire LOWER_DIGITS_ZERO_O,
   input wire EXTENDED_RES_O,
   input wire POINT_DRIVE_FIRST_O,
   input wire POINT_DRIVE_SECOND_O,
   input wire POINT_DRIVE_THIRD_O,
   input wire ATTENUATOR_TAP_A_O,
   input wire ATTENUATOR_TAP_B_O,
   input wire ATTENUATOR_TAP_C_O,
   input wire ATTENUATOR_TAP_D_O,
   input wire VOLT_CURRENT_INTEG_RESISTOR_O,
   input wire OHMS_INTEG_RESISTOR_O,
   input wire RECTIFIED_INPUT_SWITCH_O,
   input wire DIRECT_INPUT_SWITCH_O
);
   wire [2:0] dp = {POINT_DRIVE_THIRD_O, POINT_DRIVE_SECOND_O, POINT_DRIVE_FIRST_O};
   wire [3:0] taps = {ATTENUATOR_TAP_D_O, ATTENUATOR_TAP_C_O, ATTENUATOR_TAP_B_O, ATTENUATOR_TAP_A_O};
   reg [15:0] low_q;
   // low-run length; too long a low half means a slow divider
   always @(posedge CLOCK_I) begin
      if (RST_I || TONE_O) low_q <= 16'h0000;
      else low_q <= low_q + 16'h0001;
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   AST_RST_IDLE: assert property ($fell(RST_I) |-> TONE_O && DIRECT_INPUT_SWITCH_O)
      else $error("bad reset state");
   AST_INTEG: assert property ((FUNCTION_I == `MBRI_FN_OHMS) |=> OHMS_INTEG_RESISTOR_O && !VOLT_CURRENT_INTEG_RESISTOR_O)
      else $error("bad integ resistor");
   AST_AC_PATH: assert property (AC_OPTION_I && FUNCTION_I == `MBRI_FN_VOLT |=> RECTIFIED_INPUT_SWITCH_O && !DIRECT_INPUT_SWITCH_O)
      else $error("bad input path");
   AST_EXT_RES: assert property (1'b1 |=> EXTENDED_RES_O == $past(MANUAL_RANGE_I))
      else $error("bad extended res");
   AST_DP_CURR: assert property ((FUNCTION_I == `MBRI_FN_CURR) |=> dp == ($past(CURRENT_20MA_I) ? 3'h2 : 3'h1))
      else $error("bad current point");
   AST_TAP: assert property ((FUNCTION_I == `MBRI_FN_VOLT) |=> ((taps == 4'h0) == ($past(RANGE_I) == `MBRI_RG_200M)) && $countones(taps) <= 1)
      else $error("bad taps");
   AST_OVER_DISP: assert property (COUNT_VALID_I && COUNT_I > `MBRI_OVER_LIMIT && FUNCTION_I == `MBRI_FN_VOLT && !MANUAL_RANGE_I && RANGE_I != `MBRI_RG_2000 |-> ##2 LEADING_DIGIT_BLINK_O && LOWER_DIGITS_ZERO_O)
      else $error("bad overrange display");
   AST_TONE_HALF: assert property (!TONE_O |-> low_q < `MBRI_TONE_HALF)
      else $error("tone low too long");
endmodule

//--- mbri_piezo_model.sv
`timescale 1ns/100ps
// piezo load: counts falls and times each low half
module mbri_piezo_model (
   input wire clk_i,
   input wire tone_i,
   output reg [15:0] falls_o = 16'h0000,
   output reg [15:0] low_len_o = 16'h0000
);
   reg [15:0] run_q = 16'h0000;
   reg last_q = 1'b1;
   // a low half is timed from fall to rise
   always @(posedge clk_i) begin
      last_q <= tone_i;
      if (last_q && !tone_i) falls_o <= falls_o + 16'h0001;
      if (!tone_i) run_q <= run_q + 16'h0001;
      else run_q <= 16'h0000;
      if (tone_i && !last_q) low_len_o <= run_q;
   end
endmodule

//--- testbench.sv
`timescale 1ns/100ps
`include "mbri_defs.vh"
module testbench;
   reg CLOCK_I = 1'b0;
   reg RST_I = 1'b1;
   reg [1:0] FUNCTION_I = 2'h0;
   reg AC_OPTION_I = 1'b0;
   reg LOW_POWER_OHMS_OPTION_I = 1'b0;
   reg CURRENT_20MA_I = 1'b1;
   reg MANUAL_RANGE_I = 1'b0;
   reg [2:0] RANGE_I = 3'h0;
   reg [11:0] COUNT_I = 12'h000;
   reg COUNT_VALID_I = 1'b0;
   wire TONE_O, LEADING_DIGIT_BLINK_O, LOWER_DIGITS_ZERO_O, EXTENDED_RES_O;
   wire POINT_DRIVE_FIRST_O, POINT_DRIVE_SECOND_O, POINT_DRIVE_THIRD_O;
   wire ATTENUATOR_TAP_A_O, ATTENUATOR_TAP_B_O, ATTENUATOR_TAP_C_O, ATTENUATOR_TAP_D_O;
   wire VOLT_CURRENT_INTEG_RESISTOR_O, OHMS_INTEG_RESISTOR_O;
   wire RECTIFIED_INPUT_SWITCH_O, DIRECT_INPUT_SWITCH_O;
   wire [2:0] dp = {POINT_DRIVE_THIRD_O, POINT_DRIVE_SECOND_O, POINT_DRIVE_FIRST_O};
   wire [15:0] falls;
   wire [15:0] low_len;
   integer n_errors = 0;
   integer total_checks = 0;
   integer r;
   always #5 CLOCK_I = ~CLOCK_I;
   mbri_core mbri_core_inst (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .FUNCTION_I(FUNCTION_I),
      .AC_OPTION_I(AC_OPTION_I), .LOW_POWER_OHMS_OPTION_I(LOW_POWER_OHMS_OPTION_I),
      .CURRENT_20MA_I(CURRENT_20MA_I), .MANUAL_RANGE_I(MANUAL_RANGE_I), .RANGE_I(RANGE_I),
      .COUNT_I(COUNT_I), .COUNT_VALID_I(COUNT_VALID_I), .TONE_O(TONE_O),
      .LEADING_DIGIT_BLINK_O(LEADING_DIGIT_BLINK_O), .LOWER_DIGITS_ZERO_O(LOWER_DIGITS_ZERO_O),
      .EXTENDED_RES_O(EXTENDED_RES_O), .POINT_DRIVE_FIRST_O(POINT_DRIVE_FIRST_O),
      .POINT_DRIVE_SECOND_O(POINT_DRIVE_SECOND_O), .POINT_DRIVE_THIRD_O(POINT_DRIVE_THIRD_O),
      .ATTENUATOR_TAP_A_O(ATTENUATOR_TAP_A_O), .ATTENUATOR_TAP_B_O(ATTENUATOR_TAP_B_O),
      .ATTENUATOR_TAP_C_O(ATTENUATOR_TAP_C_O), .ATTENUATOR_TAP_D_O(ATTENUATOR_TAP_D_O),
      .VOLT_CURRENT_INTEG_RESISTOR_O(VOLT_CURRENT_INTEG_RESISTOR_O),
      .OHMS_INTEG_RESISTOR_O(OHMS_INTEG_RESISTOR_O),
      .RECTIFIED_INPUT_SWITCH_O(RECTIFIED_INPUT_SWITCH_O),
      .DIRECT_INPUT_SWITCH_O(DIRECT_INPUT_SWITCH_O));
   mbri_piezo_model mbri_piezo_model_inst (.clk_i(CLOCK_I), .tone_i(TONE_O), .falls_o(falls),
      .low_len_o(low_len));
   task check(input [15:0] seen, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task step(input integer n);
      repeat (n) @(negedge CLOCK_I);
   endtask
   // settings are applied under reset so no burst is owed afterwards
   task do_reset(input [1:0] fn);
      begin
         RST_I = 1'b1;
         FUNCTION_I = fn;
         AC_OPTION_I = 1'b0;
         MANUAL_RANGE_I = 1'b0;
         RANGE_I = 3'h0;
         step(2);
         check(TONE_O, 1'h1);
         check(DIRECT_INPUT_SWITCH_O, 1'h1);
         RST_I = 1'b0;
         step(2);
      end
   endtask
   task send(input [11:0] cnt);
      begin
         COUNT_I = cnt;
         COUNT_VALID_I = 1'b1;
         step(1);
         COUNT_VALID_I = 1'b0;
         step(3);
      end
   endtask
   // long enough for one half of the free square wave
   task win(input integer n, input exp);
      reg [15:0] f0;
      begin
         f0 = falls;
         step(n);
         check(falls != f0, exp);
      end
   endtask
   task t_ohms;
      begin
         do_reset(`MBRI_FN_OHMS);
         send(12'h012);
         win(25100, 1'b1);
         check(low_len, `MBRI_TONE_HALF);
         send(`MBRI_CONT_LIMIT);
         check(TONE_O, 1'h1);
         send(12'h7D1);
         check({LEADING_DIGIT_BLINK_O, LOWER_DIGITS_ZERO_O}, 2'h3);
         win(12600, 1'b0);
         // the square wave sits in its low half here, so a burst shows at once
         LOW_POWER_OHMS_OPTION_I = 1'b1;
         step(3);
         check(TONE_O, 1'h0);
      end
   endtask
   task t_over;
      begin
         do_reset(`MBRI_FN_VOLT);
         send(`MBRI_OVER_LIMIT);
         check(LEADING_DIGIT_BLINK_O, 1'h0);
         send(12'h7D1);
         check({LEADING_DIGIT_BLINK_O, LOWER_DIGITS_ZERO_O}, 2'h3);
         win(13000, 1'b1);
      end
   endtask
   task t_range;
      begin
         do_reset(`MBRI_FN_VOLT);
         RANGE_I = `MBRI_RG_20;
         win(13000, 1'b1);
         for (r = 0; r < 5; r = r + 1) begin
            RANGE_I = r[2:0];
            step(2);
            check(dp, r == 1 ? 3'h4 : r == 2 ? 3'h2 : r == 4 ? 3'h0 : 3'h1);
         end
      end
   endtask
   task t_curr;
      begin
         do_reset(`MBRI_FN_CURR);
         check(dp, 3'h2);
         RANGE_I = `MBRI_RG_200;
         CURRENT_20MA_I = 1'b0;
         win(12600, 1'b0);
         check(dp, 3'h1);
      end
   endtask
   task t_option;
      begin
         do_reset(`MBRI_FN_VOLT);
         AC_OPTION_I = 1'b1;
         MANUAL_RANGE_I = 1'b1;
         win(13000, 1'b1);
         check(RECTIFIED_INPUT_SWITCH_O, 1'h1);
         check(EXTENDED_RES_O, 1'h1);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   initial begin
      t_ohms;
      t_over;
      t_range;
      t_curr;
      t_option;
      report_and_stop;
   end
   // the sequence needs about 0.9 ms
   initial begin
      #1100000;
      n_errors = n_errors + 1;
      report_and_stop;
   end
endmodule
bind mbri_core mbri_core_monitor mbri_core_monitor_inst (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
   .FUNCTION_I(FUNCTION_I), .AC_OPTION_I(AC_OPTION_I), .CURRENT_20MA_I(CURRENT_20MA_I),
   .MANUAL_RANGE_I(MANUAL_RANGE_I), .RANGE_I(RANGE_I), .COUNT_I(COUNT_I),
   .COUNT_VALID_I(COUNT_VALID_I), .TONE_O(TONE_O), .LEADING_DIGIT_BLINK_O(LEADING_DIGIT_BLINK_O),
   .LOWER_DIGITS_ZERO_O(LOWER_DIGITS_ZERO_O), .EXTENDED_RES_O(EXTENDED_RES_O),
   .POINT_DRIVE_FIRST_O(POINT_DRIVE_FIRST_O), .POINT_DRIVE_SECOND_O(POINT_DRIVE_SECOND_O),
   .POINT_DRIVE_THIRD_O(POINT_DRIVE_THIRD_O), .ATTENUATOR_TAP_A_O(ATTENUATOR_TAP_A_O),
   .ATTENUATOR_TAP_B_O(ATTENUATOR_TAP_B_O), .ATTENUATOR_TAP_C_O(ATTENUATOR_TAP_C_O),
   .ATTENUATOR_TAP_D_O(ATTENUATOR_TAP_D_O),
   .VOLT_CURRENT_INTEG_RESISTOR_O(VOLT_CURRENT_INTEG_RESISTOR_O),
   .OHMS_INTEG_RESISTOR_O(OHMS_INTEG_RESISTOR_O),
   .RECTIFIED_INPUT_SWITCH_O(RECTIFIED_INPUT_SWITCH_O),
   .DIRECT_INPUT_SWITCH_O(DIRECT_INPUT_SWITCH_O));
